// file: hdl/gate_regs_pkg.sv
package gate_regs_pkg;

	// ----------------------------------------
	// Register map.
	// ----------------------------------------
	localparam int REG_WIDTH = 11;
	localparam logic [3:0] DRIVER_CONTROL_ADDR = 4'h2;
	localparam logic [3:0] HIGH_SIDE_GATE_DRIVE_ADDR = 4'h3;

	// ----------------------------------------
	// Driver control field positions.
	// ----------------------------------------
	localparam int DC_RESERVED_BIT = 10;
	localparam int DC_PUMP_UV_OFF_BIT = 9;
	localparam int DC_GATE_FAULT_OFF_BIT = 8;
	localparam int DC_OT_REPORT_BIT = 7;
	localparam int DC_MODE_HI = 6;
	localparam int DC_MODE_LO = 5;
	localparam int DC_FREEWHEEL_BIT = 4;
	localparam int DC_DIRECTION_BIT = 3;
	localparam int DC_COAST_BIT = 2;
	localparam int DC_BRAKE_BIT = 1;
	localparam int DC_FAULT_CLEAR_BIT = 0;

	// Bits of the driver control register that stay writable under the lock.
	localparam logic [10:0] DC_LOCKED_WRITE_MASK = 11'h007;

	// ----------------------------------------
	// High-side gate drive field positions.
	// ----------------------------------------
	localparam int HS_LOCK_HI = 10;
	localparam int HS_LOCK_LO = 8;
	localparam int HS_SOURCE_HI = 7;
	localparam int HS_SOURCE_LO = 4;
	localparam int HS_SINK_HI = 3;
	localparam int HS_SINK_LO = 0;

	// ----------------------------------------
	// Reset values and lock codes.
	// ----------------------------------------
	localparam logic [10:0] DRIVER_CONTROL_RESET = 11'h000;
	localparam logic [2:0] LOCK_ENTER_CODE = 3'h6;
	localparam logic [2:0] LOCK_LEAVE_CODE = 3'h3;
	localparam logic [3:0] SOURCE_CURRENT_RESET = 4'hF;
	localparam logic [3:0] SINK_CURRENT_RESET = 4'hF;

	// Input schemes.
	typedef enum logic [1:0] {
		MODE_SIX_INPUT = 2'h0,
		MODE_THREE_INPUT = 2'h1,
		MODE_SINGLE_INPUT = 2'h2,
		MODE_INDEPENDENT = 2'h3
	} input_mode_t;

	// Register access request from the serial front end.
	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [3:0] addr;
		logic [10:0] wdata;
	} reg_req_t;

	// Settings handed to the drive stage.
	typedef struct packed {
		input_mode_t mode;
		logic freewheel_async;
		logic direction;
		logic coast;
		logic brake;
		logic [3:0] source_current;
		logic [3:0] sink_current;
	} drive_cfg_t;

endpackage

// file: hdl/gate_driver_control_regs.sv
`timescale 1ns/1ps
`default_nettype none

module gate_driver_control_regs
	import gate_regs_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Register access from the serial front end.
	input wire reg_req_t req,
	output logic [10:0] rdata,
	output logic rvalid,
	// Raw fault and warning events, already on this clock.
	input wire logic pump_undervolt,
	input wire logic gate_drive_fault,
	input wire logic overtemp_warning,
	input wire logic other_fault,
	// Single-input direction and brake pins.
	input wire logic phase_c_high_input,
	input wire logic phase_c_low_input,
	// Outputs to the drive stage and fault logic.
	output drive_cfg_t drive_cfg,
	output logic effective_direction,
	output logic effective_brake,
	output logic all_high_z,
	output logic low_side_freewheel_off,
	output logic gate_fault_action_en,
	output logic fault_clear,
	output logic [3:0] fault_status,
	output logic summary_fault,
	output logic fault_out_n
);

	// ----------------------------------------
	// Register storage.
	// ----------------------------------------
	logic [10:0] dc_r;
	logic [2:0] lock_r;
	logic [3:0] src_r;
	logic [3:0] snk_r;
	logic locked;
	logic wr_dc;
	logic wr_hs;
	logic [10:0] dc_mask;
	logic [3:0] latch_r;
	logic [3:0] latch_nxt;
	logic sum_nxt;
	logic single;
	logic [2:0] dir_sync_r;
	logic [2:0] brake_sync_r;
	logic dir_pin_r;
	logic brake_pin_r;

	assign locked = (lock_r == LOCK_ENTER_CODE);
	assign wr_dc = req.wr_en && (req.addr == DRIVER_CONTROL_ADDR);
	assign wr_hs = req.wr_en && (req.addr == HIGH_SIDE_GATE_DRIVE_ADDR);
	assign dc_mask = locked ? DC_LOCKED_WRITE_MASK : 11'h7FF;

	// Driver control register; the clear bit is never stored and always reads as 0.
	always_ff @(posedge clk) begin
		if (rst) begin
			dc_r <= DRIVER_CONTROL_RESET;
		end else begin
			dc_r[DC_FAULT_CLEAR_BIT] <= 1'b0;
			if (wr_dc) begin
				dc_r <= ((dc_r & ~dc_mask) | (req.wdata & dc_mask)) & ~11'h001;
			end
		end
	end

	// Lock field: 110b locks when unlocked, 011b unlocks when locked.
	always_ff @(posedge clk) begin
		if (rst) begin
			lock_r <= LOCK_LEAVE_CODE;
		end else if (wr_hs) begin
			if (!locked && req.wdata[HS_LOCK_HI:HS_LOCK_LO] == LOCK_ENTER_CODE) begin
				lock_r <= LOCK_ENTER_CODE;
			end else if (locked && req.wdata[HS_LOCK_HI:HS_LOCK_LO] == LOCK_LEAVE_CODE) begin
				lock_r <= LOCK_LEAVE_CODE;
			end
		end
	end

	// Gate current codes, frozen while locked.
	always_ff @(posedge clk) begin
		if (rst) begin
			src_r <= SOURCE_CURRENT_RESET;
			snk_r <= SINK_CURRENT_RESET;
		end else if (wr_hs && !locked) begin
			src_r <= req.wdata[HS_SOURCE_HI:HS_SOURCE_LO];
			snk_r <= req.wdata[HS_SINK_HI:HS_SINK_LO];
		end
	end

	// ----------------------------------------
	// Read path.
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 11'h000;
			rvalid <= 1'b0;
		end else begin
			rvalid <= req.rd_en;
			if (req.rd_en) begin
				case (req.addr)
					DRIVER_CONTROL_ADDR: rdata <= dc_r;
					HIGH_SIDE_GATE_DRIVE_ADDR: rdata <= {lock_r, src_r, snk_r};
					default: rdata <= 11'h000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Fault latches: bit 0 pump, 1 gate, 2 warning, 3 other.
	// ----------------------------------------
	always_comb begin
		latch_nxt = latch_r;
		if (fault_clear) begin
			latch_nxt = 4'h0;
		end
		if (pump_undervolt && !dc_r[DC_PUMP_UV_OFF_BIT]) begin
			latch_nxt[0] = 1'b1;
		end
		if (gate_drive_fault && !dc_r[DC_GATE_FAULT_OFF_BIT]) begin
			latch_nxt[1] = 1'b1;
		end
		if (overtemp_warning) begin
			latch_nxt[2] = 1'b1;
		end
		if (other_fault) begin
			latch_nxt[3] = 1'b1;
		end
		// The warning counts toward the summary only when reporting is on.
		sum_nxt = latch_nxt[0] | latch_nxt[1] | latch_nxt[3] |
			(latch_nxt[2] & dc_r[DC_OT_REPORT_BIT]);
	end

	// Latches and the summary stay aligned so the pin and bit always agree.
	always_ff @(posedge clk) begin
		if (rst) begin
			latch_r <= 4'h0;
			fault_status <= 4'h0;
			summary_fault <= 1'b0;
			fault_out_n <= 1'b1;
		end else begin
			latch_r <= latch_nxt;
			fault_status <= latch_nxt;
			summary_fault <= sum_nxt;
			fault_out_n <= ~sum_nxt;
		end
	end

	// ----------------------------------------
	// Pin synchronisers.
	// ----------------------------------------
	// The direction and brake pins are asynchronous, so each passes three flops and a level counts
	// only once the last two agree, which keeps a metastable sample out of the drive stage.
	always_ff @(posedge clk) begin
		if (rst) begin
			dir_sync_r <= 3'h0;
			brake_sync_r <= 3'h0;
			dir_pin_r <= 1'b0;
			brake_pin_r <= 1'b0;
		end else begin
			dir_sync_r <= {dir_sync_r[1:0], phase_c_high_input};
			brake_sync_r <= {brake_sync_r[1:0], phase_c_low_input};
			if (dir_sync_r[1] == dir_sync_r[2]) begin
				dir_pin_r <= dir_sync_r[2];
			end
			if (brake_sync_r[1] == brake_sync_r[2]) begin
				brake_pin_r <= brake_sync_r[2];
			end
		end
	end

	// ----------------------------------------
	// Drive stage settings.
	// ----------------------------------------
	assign single = (dc_r[DC_MODE_HI:DC_MODE_LO] == MODE_SINGLE_INPUT);

	always_ff @(posedge clk) begin
		if (rst) begin
			drive_cfg <= '{mode: MODE_SIX_INPUT, freewheel_async: 1'b0, direction: 1'b0, coast: 1'b0,
				brake: 1'b0, source_current: SOURCE_CURRENT_RESET, sink_current: SINK_CURRENT_RESET};
			effective_direction <= 1'b0;
			effective_brake <= 1'b0;
			all_high_z <= 1'b0;
			low_side_freewheel_off <= 1'b0;
			gate_fault_action_en <= 1'b1;
			fault_clear <= 1'b0;
		end else begin
			drive_cfg.mode <= input_mode_t'(dc_r[DC_MODE_HI:DC_MODE_LO]);
			drive_cfg.freewheel_async <= dc_r[DC_FREEWHEEL_BIT];
			drive_cfg.direction <= dc_r[DC_DIRECTION_BIT];
			drive_cfg.coast <= dc_r[DC_COAST_BIT];
			drive_cfg.brake <= dc_r[DC_BRAKE_BIT];
			drive_cfg.source_current <= src_r;
			drive_cfg.sink_current <= snk_r;
			effective_direction <= single & (dc_r[DC_DIRECTION_BIT] | dir_pin_r);
			effective_brake <= single & (dc_r[DC_BRAKE_BIT] | brake_pin_r);
			all_high_z <= dc_r[DC_COAST_BIT];
			low_side_freewheel_off <= single & dc_r[DC_FREEWHEEL_BIT];
			gate_fault_action_en <= ~dc_r[DC_GATE_FAULT_OFF_BIT];
			fault_clear <= wr_dc & req.wdata[DC_FAULT_CLEAR_BIT];
		end
	end

	// ----------------------------------------
	// Checks.
	// ----------------------------------------
	sequence lock_write_s;
		wr_hs && !locked && req.wdata[HS_LOCK_HI:HS_LOCK_LO] == LOCK_ENTER_CODE;
	endsequence

	lock_enter_a: assert property (@(posedge clk) disable iff (rst) lock_write_s |=> locked)
		else $error("lock code did not lock");
	locked_freeze_a: assert property (@(posedge clk) disable iff (rst)
		locked && wr_hs |=> $stable(src_r) && $stable(snk_r))
		else $error("current codes changed while locked");
	unlock_only_a: assert property (@(posedge clk) disable iff (rst)
		locked && wr_hs && req.wdata[HS_LOCK_HI:HS_LOCK_LO] != LOCK_LEAVE_CODE |=> locked)
		else $error("wrong code unlocked");
	clear_self_a: assert property (@(posedge clk) disable iff (rst)
		wr_dc && req.wdata[DC_FAULT_CLEAR_BIT] ##1 !(wr_dc && req.wdata[DC_FAULT_CLEAR_BIT])
		|-> fault_clear ##1 !fault_clear)
		else $error("fault clear not a single pulse");
	clear_bit_zero_a: assert property (@(posedge clk) disable iff (rst) ##1 !dc_r[DC_FAULT_CLEAR_BIT])
		else $error("fault clear bit stuck");
	pin_tracks_sum_a: assert property (@(posedge clk) disable iff (rst) fault_out_n == !summary_fault)
		else $error("fault pin disagrees with summary");
	pump_mask_a: assert property (@(posedge clk) disable iff (rst)
		dc_r[DC_PUMP_UV_OFF_BIT] && !latch_r[0] && !fault_clear |=> !latch_r[0])
		else $error("suppressed pump fault latched");
	warn_hidden_a: assert property (@(posedge clk) disable iff (rst)
		!dc_r[DC_OT_REPORT_BIT] && latch_nxt[1:0] == 2'h0 && !latch_nxt[3] |=> !summary_fault)
		else $error("warning reported while off");
	coast_follow_a: assert property (@(posedge clk) disable iff (rst) dc_r[DC_COAST_BIT] |=> all_high_z)
		else $error("coast not applied");
	brake_or_a: assert property (@(posedge clk) disable iff (rst)
		single && brake_pin_r |=> effective_brake)
		else $error("brake pin ignored");

endmodule // gate_driver_control_regs

`default_nettype wire

// file: verification/host_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_model
	import gate_regs_pkg::*;
(
	// Clock.
	input wire logic clk,
	// Register bus.
	output var reg_req_t req,
	input wire logic [10:0] rdata,
	input wire logic rvalid
);
	// The bus idles with no strobe.
	initial req = '0;

	// One write, taken at the edge after set-up; released lines show inverted values.
	task automatic wr(input logic [3:0] a, input logic [10:0] d);
		@(posedge clk);
		#2 req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		#2 req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
	endtask

	// One read; valid and data stand for the one cycle after the request edge and are taken there.
	task automatic rd(input logic [3:0] a, output logic [10:0] d, output logic v);
		@(posedge clk);
		#2 req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 11'h7FF};
		@(posedge clk);
		#2 req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: 11'h000};
		d = rdata;
		v = rvalid;
	endtask
endmodule // host_model

`default_nettype wire

// file: verification/gate_driver_control_regs_test.sv
`timescale 1ns/1ps
`default_nettype none

module gate_driver_control_regs_test;
	import gate_regs_pkg::*;
	logic clk, rst, dir_pin, brake_pin, rvalid, clr, summ, fault_n, eff_dir, eff_brk, high_z, fw_off, gf_en, v;
	logic [3:0] flt, fstat;
	logic [10:0] rdata, d;
	int errors, check_count;
	reg_req_t req;
	drive_cfg_t cfg;

	// Clock at 25 ns.
	initial begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end

	host_model i_host_model (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

	gate_driver_control_regs i_gate_driver_control_regs (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
		.rvalid(rvalid), .pump_undervolt(flt[0]), .gate_drive_fault(flt[1]), .overtemp_warning(flt[2]),
		.other_fault(flt[3]), .phase_c_high_input(dir_pin), .phase_c_low_input(brake_pin), .drive_cfg(cfg),
		.effective_direction(eff_dir), .effective_brake(eff_brk), .all_high_z(high_z),
		.low_side_freewheel_off(fw_off), .gate_fault_action_en(gf_en), .fault_clear(clr),
		.fault_status(fstat), .summary_fault(summ), .fault_out_n(fault_n));

	// ----
	// Shared helpers.
	// ----
	task automatic chk(input logic [10:0] g, input logic [10:0] e);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask

	task automatic step();
		@(posedge clk);
		#2;
	endtask

	// Reads a register and checks the value and its valid pulse.
	task automatic rdc(input logic [3:0] a, input logic [10:0] e);
		i_host_model.rd(a, d, v);
		chk(v, 1);
		chk(d, e);
	endtask

	// Writes and lets the derived outputs settle.
	task automatic wr(input logic [3:0] a, input logic [10:0] x);
		i_host_model.wr(a, x);
		step();
	endtask

	// One-cycle fault event.
	task automatic pulse(input int i);
		step();
		flt[i] = 1;
		step();
		flt = 0;
	endtask

	// ----
	// Scenarios.
	// ----
	task automatic t_reset();
		rdc(2, 11'h000);
		rdc(3, 11'h3FF);
		chk({summ, fault_n, gf_en}, 3'b011);
		chk({high_z, eff_dir, eff_brk, fw_off}, 4'b0000);
	endtask

	task automatic t_fields();
		wr(2, 11'h458);
		rdc(2, 11'h458);
		chk({eff_dir, fw_off, high_z, eff_brk}, 4'b1100);
		chk({cfg.freewheel_async, cfg.direction, cfg.coast, cfg.brake}, 4'b1100);
		dir_pin = 1;
		repeat (4) step();
		wr(2, 11'h442);
		chk({eff_dir, fw_off, eff_brk}, 3'b101);
		brake_pin = 1;
		repeat (4) step();
		wr(2, 11'h440);
		chk({eff_dir, eff_brk, high_z}, 3'b110);
		wr(2, 11'h004);
		chk({eff_dir, eff_brk, high_z}, 3'b001);
		chk({cfg.coast, cfg.brake}, 2'b10);
		dir_pin = 0;
		brake_pin = 0;
		for (int m = 0; m < 4; m++) begin
			wr(2, 11'(m << 5));
			chk(cfg.mode, 11'(m));
		end
	endtask

	task automatic t_lock();
		wr(3, 11'h3A5);
		chk({cfg.source_current, cfg.sink_current}, 11'h0A5);
		wr(2, 11'h000);
		wr(3, 11'h5A5);
		rdc(3, 11'h3A5);
		wr(3, 11'h6A5);
		wr(3, 11'h611);
		rdc(3, 11'h6A5);
		wr(2, 11'h7FC);
		rdc(2, 11'h004);
		wr(3, 11'h5A5);
		rdc(3, 11'h6A5);
		wr(3, 11'h3A5);
		wr(3, 11'h300);
		rdc(3, 11'h300);
	endtask

	task automatic t_faults();
		wr(2, 11'h000);
		pulse(0);
		chk({fstat, summ, fault_n}, 6'b000110);
		i_host_model.wr(2, 11'h001);
		chk({clr, fstat}, 5'b10001);
		step();
		chk({clr, fstat}, 5'b00000);
		chk({summ, fault_n}, 2'b01);
		rdc(2, 11'h000);
		wr(2, 11'h380);
		chk(gf_en, 0);
		pulse(0);
		pulse(1);
		chk(fstat, 0);
		pulse(2);
		chk({fstat, summ}, 5'b01001);
		wr(2, 11'h001);
		step();
		pulse(2);
		chk({fstat, summ, fault_n}, 6'b010001);
		pulse(3);
		chk({summ, fault_n}, 2'b10);
	endtask

	// Verdict and end of run.
	task automatic tally_and_finish();
		if (errors == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// Main sequence.
	initial begin
		rst = 1;
		flt = 0;
		dir_pin = 0;
		brake_pin = 0;
		repeat (5) @(posedge clk);
		#2 rst = 0;
		t_reset();
		t_fields();
		t_lock();
		t_faults();
		tally_and_finish();
	end

	// Watchdog well beyond the hundred or so cycles the scenarios need.
	initial begin
		#100000;
		errors++;
		tally_and_finish();
	end
endmodule // gate_driver_control_regs_test

`default_nettype wire
